// ### rtl/sqp_device.sv
`timescale 1ns/10ps
// Behaviour
// [R1] Alert is open-drain, active low.
// [R2] Alert asserts on any pin edge.
// [R3] Alert releases when pins match snapshot.
// [R4] Write releases alert at data acknowledge.
// [R5] Read releases at address acknowledge, read.
// [R6] Changes near strobes may be missed.
// [R7] Later pin changes assert alert again.
// [R8] Reset reference high; low pin alerts.
// [R9] One bit per clock, stable high.
// [R10] START and STOP detected while clock high.
// [R11] Master starts only on free bus.
// [R12] Each byte followed by one acknowledge.
// [R13] Unlimited bytes between START and STOP.
// [R14] Device acknowledges every received byte.
// [R15] Master acknowledges bytes it reads.
// [R16] Unacknowledged byte ends read, device releases.
// [R17] Master writes ones to input pins.
// [R18] Port read returns actual pin levels.
// [R19] Written byte applied after its acknowledge.
// [R20] Reset sets latch high and idle.
// [R21] Snapshot taken at clearing accesses.
module sqp_device (
	input wire logic sys_clk,
	input wire logic rst,
	sqp_link_if.device link,
	input wire logic [6:0] slaveAddr,
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	output logic writeStrobe,
	output logic readStrobe
);
	typedef enum logic [2:0] {
		SQP_IDLE = 3'b000,
		SQP_ADDR = 3'b001,
		SQP_AACK = 3'b010,
		SQP_WDATA = 3'b011,
		SQP_WACK = 3'b100,
		SQP_RDATA = 3'b101,
		SQP_RACK = 3'b110
	} sqp_state_t;
	sqp_state_t state_r;
	logic [1:0] sclSync_r, sdaSync_r;
	logic [7:0] pinSync1_r, pinSync2_r;
	logic sclPrev_r, sdaPrev_r;
	logic [7:0] shift_r, port_r, snap_r, txByte_r;
	logic [3:0] bitCnt_r;
	logic rnw_r, match_r, sdaDrive_r;
	logic sclRise, sclFall, startCond, stopCond, clearEv;
	logic [2:0] wrDly_r;
	assign sclRise = sclSync_r[1] & ~sclPrev_r;
	assign sclFall = ~sclSync_r[1] & sclPrev_r;
	// [R10] START STOP detect.
	assign startCond = sclSync_r[1] & sclPrev_r & sdaPrev_r & ~sdaSync_r[1];
	assign stopCond = sclSync_r[1] & sclPrev_r & ~sdaPrev_r & sdaSync_r[1];
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			pinSync1_r <= sqp_pkg::PORT_RESET;
			pinSync2_r <= sqp_pkg::PORT_RESET;
		end else begin
			sclSync_r <= {sclSync_r[0], link.scl};
			sdaSync_r <= {sdaSync_r[0], link.sda};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
			pinSync1_r <= pinIn;
			pinSync2_r <= pinSync1_r;
		end
	end
	// [R9] Bit sampling protocol.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= SQP_IDLE;
			shift_r <= 8'h00;
			bitCnt_r <= 4'h0;
			rnw_r <= 1'b0;
			match_r <= 1'b0;
		end else if (startCond) begin
			state_r <= SQP_ADDR;
			bitCnt_r <= 4'h0;
		end else if (stopCond) begin
			state_r <= SQP_IDLE;
		end else begin
			unique case (state_r)
				SQP_IDLE: begin
				end
				SQP_ADDR, SQP_WDATA: begin
					if (sclRise) begin
						shift_r <= {shift_r[6:0], sdaSync_r[1]};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					// [R12] Acknowledge after eight.
					if (sclFall && bitCnt_r == 4'(sqp_pkg::BYTE_BITS)) begin
						bitCnt_r <= 4'h0;
						if (state_r == SQP_WDATA) begin
							state_r <= SQP_WACK;
						end else if (shift_r[7:1] == slaveAddr) begin
							rnw_r <= shift_r[0];
							match_r <= 1'b1;
							state_r <= SQP_AACK;
						end else begin
							match_r <= 1'b0;
							state_r <= SQP_IDLE;
						end
					end
				end
				SQP_AACK: begin
					if (sclFall) begin
						state_r <= rnw_r ? SQP_RDATA : SQP_WDATA;
					end
				end
				// [R13] Loop for more bytes.
				SQP_WACK: begin
					if (sclFall) begin
						state_r <= SQP_WDATA;
					end
				end
				SQP_RDATA: begin
					if (sclFall) begin
						bitCnt_r <= bitCnt_r + 4'h1;
						if (bitCnt_r == 4'(sqp_pkg::BYTE_BITS - 1)) begin
							bitCnt_r <= 4'h0;
							state_r <= SQP_RACK;
						end
					end
				end
				// [R16] Nack ends read.
				SQP_RACK: begin
					if (sclRise) begin
						match_r <= ~sdaSync_r[1];
					end
					if (sclFall) begin
						state_r <= match_r ? SQP_RDATA : SQP_IDLE;
					end
				end
				default: begin
					state_r <= SQP_IDLE;
				end
			endcase
		end
	end
	// [R18] Read strobe captures pins.
	assign readStrobe = (state_r == SQP_AACK && rnw_r && sclFall) ||
		(state_r == SQP_RACK && match_r && sclFall);
	// [R19] Apply after acknowledge.
	assign writeStrobe = (state_r == SQP_WACK) && sclFall;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txByte_r <= 8'hFF;
		end else if (readStrobe) begin
			txByte_r <= pinSync2_r;
		end else if (state_r == SQP_RDATA && sclFall) begin
			txByte_r <= {txByte_r[6:0], 1'b1};
		end
	end
	// [R14] Drive acknowledge low.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sdaDrive_r <= 1'b0;
		end else if (startCond || stopCond) begin
			sdaDrive_r <= 1'b0;
		end else if (sclFall) begin
			if (state_r == SQP_ADDR && bitCnt_r == 4'(sqp_pkg::BYTE_BITS)) begin
				sdaDrive_r <= shift_r[7:1] == slaveAddr;
			end else if (state_r == SQP_WDATA && bitCnt_r == 4'(sqp_pkg::BYTE_BITS)) begin
				sdaDrive_r <= 1'b1;
			end else if (state_r == SQP_AACK && rnw_r) begin
				sdaDrive_r <= ~pinSync2_r[7];
			end else if (state_r == SQP_RACK && match_r) begin
				sdaDrive_r <= ~pinSync2_r[7];
			end else if (state_r == SQP_RDATA && bitCnt_r != 4'(sqp_pkg::BYTE_BITS - 1)) begin
				sdaDrive_r <= ~txByte_r[6];
			end else begin
				sdaDrive_r <= 1'b0;
			end
		end
	end
	assign link.sdaDevOut = 1'b0;
	assign link.sdaDevOe = sdaDrive_r;
	// [R20] Port latch reset high.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			port_r <= sqp_pkg::PORT_RESET;
		end else if (writeStrobe) begin
			port_r <= shift_r;
		end
	end
	assign pinOut = 8'h00;
	assign pinOe = ~port_r;
	// [R6] Settle after write.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wrDly_r <= 3'h0;
		end else begin
			wrDly_r <= {wrDly_r[1:0], writeStrobe};
		end
	end
	// [R4] Clear on write.
	// [R5] Clear on read.
	assign clearEv = writeStrobe || readStrobe || wrDly_r[2] ||
		(state_r == SQP_AACK && rnw_r && sclRise);
	// [R21] Snapshot at access.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			snap_r <= sqp_pkg::SNAP_RESET;
		end else if (clearEv) begin
			snap_r <= pinSync2_r;
		end
	end
	// [R2] Any difference alerts once wrDly_r is clear.
	// [R3] Release on match.
	// [R7] Rearms after clear.
	// [R8] Reset snapshot high.
	// [R1] Open-drain low.
	assign link.alertOut = 1'b0;
	assign link.alertOe = ~|wrDly_r && (pinSync2_r != snap_r);
endmodule

// ### rtl/sqp_host.sv
`timescale 1ns/10ps
module sqp_host (
	input wire logic sys_clk,
	input wire logic rst,
	sqp_link_if.host link,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqRead,
	input wire logic [6:0] reqAddr,
	input wire logic [7:0] reqData,
	input wire logic [3:0] reqCount,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic ackErr,
	output logic alertSeen
);
	typedef enum logic [2:0] {
		SQH_IDLE = 3'b000,
		SQH_START = 3'b001,
		SQH_BITS = 3'b010,
		SQH_ACK = 3'b011,
		SQH_STOP = 3'b100,
		SQH_DONE = 3'b101
	} sqh_state_t;
	sqh_state_t state_r;
	logic [7:0] cnt_r, shift_r, rx_r;
	logic [3:0] bitCnt_r, left_r;
	logic [1:0] phase_r, sdaSync_r, alSync_r;
	logic tick, sclO_r, sdaO_r, isAddr_r, rd_r;
	logic [7:0] wdata_r;
	assign tick = cnt_r == 8'(sqp_pkg::SCL_HALF_CYC / 2 - 1);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
			sdaSync_r <= 2'h3;
			alSync_r <= 2'h3;
		end else begin
			cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
			sdaSync_r <= {sdaSync_r[0], link.sda};
			alSync_r <= {alSync_r[0], link.alertN};
		end
	end
	assign alertSeen = ~alSync_r[1];
	// [R11] Start only when idle.
	assign reqReady = state_r == SQH_IDLE;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= SQH_IDLE;
			phase_r <= 2'h0;
			sclO_r <= 1'b1;
			sdaO_r <= 1'b1;
			shift_r <= 8'h00;
			rx_r <= 8'h00;
			bitCnt_r <= 4'h0;
			left_r <= 4'h0;
			isAddr_r <= 1'b0;
			rd_r <= 1'b0;
			wdata_r <= 8'h00;
			rdValid <= 1'b0;
			rdData <= 8'h00;
			ackErr <= 1'b0;
		end else begin
			rdValid <= 1'b0;
			if (state_r == SQH_IDLE) begin
				if (reqValid) begin
					state_r <= SQH_START;
					shift_r <= {reqAddr, reqRead};
					rd_r <= reqRead;
					wdata_r <= reqData;
					left_r <= reqCount;
					isAddr_r <= 1'b1;
					ackErr <= 1'b0;
					phase_r <= 2'h0;
				end
			end else if (tick) begin
				phase_r <= phase_r + 2'h1;
				unique case (state_r)
					// [R10] SDA falls with SCL high.
					SQH_START: begin
						if (phase_r == 2'h1) sdaO_r <= 1'b0;
						if (phase_r == 2'h3) begin
							sclO_r <= 1'b0;
							state_r <= SQH_BITS;
							bitCnt_r <= 4'h0;
						end
					end
					// [R9] Change data while low.
					SQH_BITS: begin
						unique case (phase_r)
							2'h0: sdaO_r <= (isAddr_r || !rd_r) ? shift_r[7] : 1'b1;
							2'h1: sclO_r <= 1'b1;
							2'h2: rx_r <= {rx_r[6:0], sdaSync_r[1]};
							2'h3: begin
								sclO_r <= 1'b0;
								shift_r <= {shift_r[6:0], 1'b0};
								bitCnt_r <= bitCnt_r + 4'h1;
								if (bitCnt_r == 4'(sqp_pkg::BYTE_BITS - 1)) state_r <= SQH_ACK;
							end
						endcase
					end
					// [R15] Ack reads, [R16] nack last.
					SQH_ACK: begin
						unique case (phase_r)
							2'h0: sdaO_r <= (!isAddr_r && rd_r) ? (left_r <= 4'h1) : 1'b1;
							2'h1: sclO_r <= 1'b1;
							2'h2: begin
								// [R12] Check receiver acknowledge.
								if ((isAddr_r || !rd_r) && sdaSync_r[1]) ackErr <= 1'b1;
								if (!isAddr_r && rd_r) begin
									rdData <= rx_r;
									rdValid <= 1'b1;
								end
							end
							2'h3: begin
								sclO_r <= 1'b0;
								bitCnt_r <= 4'h0;
								// [R13] Repeat for count.
								if (!isAddr_r) left_r <= left_r - 4'h1;
								isAddr_r <= 1'b0;
								shift_r <= wdata_r;
								// [R17] Host data from user.
								if (ackErr || (!isAddr_r && left_r <= 4'h1) ||
									(isAddr_r && left_r == 4'h0)) begin
									state_r <= SQH_STOP;
								end else begin
									state_r <= SQH_BITS;
								end
							end
						endcase
					end
					SQH_STOP: begin
						if (phase_r == 2'h0) sdaO_r <= 1'b0;
						if (phase_r == 2'h1) sclO_r <= 1'b1;
						if (phase_r == 2'h3) begin
							sdaO_r <= 1'b1;
							state_r <= SQH_DONE;
						end
					end
					SQH_DONE: begin
						state_r <= SQH_IDLE;
					end
					default: state_r <= SQH_IDLE;
				endcase
			end
		end
	end
	assign link.sclOut = 1'b0;
	assign link.sclOe = ~sclO_r;
	assign link.sdaHostOut = 1'b0;
	assign link.sdaHostOe = ~sdaO_r;
endmodule

// ### rtl/sqp_link_if.sv
`timescale 1ns/10ps
interface sqp_link_if;
	logic sclOut;
	logic sclOe;
	logic sdaDevOut;
	logic sdaDevOe;
	logic sdaHostOut;
	logic sdaHostOe;
	logic alertOut;
	logic alertOe;
	logic scl;
	logic sda;
	logic alertN;
	assign scl = sclOe ? sclOut : 1'b1;
	assign sda = (sdaDevOe & ~sdaDevOut) | (sdaHostOe & ~sdaHostOut) ? 1'b0 : 1'b1;
	assign alertN = (alertOe & ~alertOut) ? 1'b0 : 1'b1;
	modport device (input scl, input sda, output sdaDevOut, output sdaDevOe,
		output alertOut, output alertOe);
	modport host (input scl, input sda, input alertN, output sclOut, output sclOe,
		output sdaHostOut, output sdaHostOe);
endinterface

// ### rtl/sqp_pkg.sv
package sqp_pkg;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int SCL_PERIOD_NS = 2000;
	localparam int SCL_HALF_CYC = (SCL_PERIOD_NS * (SYS_CLK_HZ / 1000000)) / 2000;
	localparam int SCL_CNT_W = 8;
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h20;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [7:0] SNAP_RESET = 8'hFF;
	localparam int BYTE_BITS = 8;
endpackage

// ### test/sqp_link_asserts.sv
`timescale 1ns/10ps
module sqp_link_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaDevOut,
	input wire logic sdaDevOe,
	input wire logic sdaHostOut,
	input wire logic sdaHostOe,
	input wire logic alertOut,
	input wire logic alertOe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_alert_drives_low: assert property (alertOe |-> !alertOut)
		else $error("alert driven high");
	a_dev_sda_low: assert property (sdaDevOe |-> !sdaDevOut)
		else $error("device drives data high");
	a_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sdaDevOe))
		else $error("device data changed while clock high");
	a_host_scl_low: assert property (sclOe |-> !sclOut)
		else $error("host clock driven high");
	a_host_sda_low: assert property (sdaHostOe |-> !sdaHostOut)
		else $error("host drives data high");
	a_no_sda_clash: assert property (scl |-> !(sdaDevOe && sdaHostOe))
		else $error("both ends pull data in one high phase");
	a_idle_after_reset: assert property ($fell(rst) |-> scl && sda && !sdaDevOe)
		else $error("bus not idle after reset");
	a_quiet_after_stop: assert property ($rose(sda) && scl && $past(scl) |=> !sdaDevOe [*8])
		else $error("device drives data after stop");
endmodule

// ### test/tb_serial_quasi_bidir_port_irq.sv
`timescale 1ns/10ps
module tb_serial_quasi_bidir_port_irq;
	localparam logic [6:0] ADDR = sqp_pkg::SLAVE_ADDR_DEF;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] extLvl = 8'hFE;
	logic [7:0] pinOe;
	logic reqValid = 1'b0;
	logic reqReady;
	logic reqRead = 1'b0;
	logic [6:0] reqAddr = 7'h00;
	logic [7:0] reqData = 8'h00;
	logic [3:0] reqCount = 4'h0;
	logic rdValid;
	logic [7:0] rdData;
	logic ackErr;
	logic alertSeen;
	logic [7:0] pinOut;
	logic wrStb;
	logic rdStb;
	int nWr = 0;
	int nStb = 0;
	logic [7:0] rdBuf [16];
	int nRd;
	int errCount = 0;
	int numChecks = 0;
	sqp_link_if link ();
	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		if (wrStb === 1'b1) begin
			nWr++;
		end
		if (rdStb === 1'b1) begin
			nStb++;
		end
	end
	sqp_device i_sqp_device (.sys_clk(sys_clk), .rst(rst), .link(link), .slaveAddr(ADDR),
		.pinIn(extLvl & ~pinOe), .pinOut(pinOut), .pinOe(pinOe), .writeStrobe(wrStb),
		.readStrobe(rdStb));
	sqp_host i_sqp_host (.sys_clk(sys_clk), .rst(rst), .link(link), .reqValid(reqValid),
		.reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
		.reqCount(reqCount), .rdValid(rdValid), .rdData(rdData), .ackErr(ackErr),
		.alertSeen(alertSeen));
	sqp_link_asserts i_sqp_link_asserts (.sys_clk(sys_clk), .rst(rst), .sclOut(link.sclOut),
		.sclOe(link.sclOe), .sdaDevOut(link.sdaDevOut), .sdaDevOe(link.sdaDevOe),
		.sdaHostOut(link.sdaHostOut), .sdaHostOe(link.sdaHostOe), .alertOut(link.alertOut),
		.alertOe(link.alertOe), .scl(link.scl), .sda(link.sda));
	task automatic giveVerdict();
		if (errCount == 0 && numChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic alertIs(input logic exp);
		check({7'h00, link.alertN}, {7'h00, exp});
		check({7'h00, alertSeen}, {7'h00, ~exp});
	endtask
	task automatic setPins(input logic [7:0] v);
		@(posedge sys_clk);
		extLvl <= v;
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
		input logic [3:0] n);
		int k;
		k = 0;
		nRd = 0;
		@(posedge sys_clk);
		reqRead <= rd;
		reqAddr <= a;
		reqData <= d;
		reqCount <= n;
		reqValid <= 1'b1;
		do begin
			@(negedge sys_clk);
			k++;
		end while (reqReady !== 1'b1 && k < 100);
		if (reqReady !== 1'b1) begin
			errCount++;
		end
		@(posedge sys_clk);
		reqValid <= 1'b0;
		do begin
			@(negedge sys_clk);
			if (rdValid === 1'b1) begin
				rdBuf[nRd] = rdData;
				nRd++;
			end
			k++;
		end while (reqReady !== 1'b1 && k < 20000);
		if (k >= 20000) begin
			errCount++;
			giveVerdict();
		end
		repeat (6) @(negedge sys_clk);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (6) @(negedge sys_clk);
		alertIs(1'b0); // Low pin alerts.
		check(pinOe, 8'h00); // Pins released.
		check(pinOut, 8'h00); // Pins only pull low.
		xfer(1'b1, ADDR, 8'h00, 4'h1);
		check(rdBuf[0], 8'hFE); // Read pins.
		alertIs(1'b1); // Read clears.
		setPins(8'hFF);
		alertIs(1'b0); // Rising edge alerts.
		setPins(8'hFE);
		alertIs(1'b1); // Return clears.
		setPins(8'hFF);
		alertIs(1'b0); // Rising edge again.
		xfer(1'b1, ADDR, 8'h00, 4'h0);
		alertIs(1'b1); // Address ack clears.
		xfer(1'b0, ADDR, 8'h5A, 4'h3);
		check(pinOe, 8'hA5); // Byte applied.
		check({7'h00, ackErr}, 8'h00); // Bytes acknowledged.
		alertIs(1'b1); // Write clears.
		check(nWr[7:0], 8'h03); // One strobe per byte.
		xfer(1'b1, ADDR, 8'h00, 4'h3);
		check(nRd[7:0], 8'h03); // Last byte ends read.
		check(nStb[7:0], 8'h05); // Capture per acknowledge.
		for (int i = 0; i < 3; i++) begin
			check(rdBuf[i], 8'h5A); // Repeated bytes.
		end
		setPins(8'hFD);
		alertIs(1'b0); // Alert again later.
		xfer(1'b0, ADDR, 8'hFF, 4'h1);
		check(pinOe, 8'h00); // Inputs written high.
		alertIs(1'b1); // Release settles.
		xfer(1'b1, ADDR, 8'h00, 4'h1);
		check(rdBuf[0], 8'hFD); // Input level read.
		alertIs(1'b1); // Read clears.
		xfer(1'b0, ADDR ^ 7'h01, 8'h00, 4'h1);
		check({7'h00, ackErr}, 8'h01); // Other address unanswered.
		check(pinOe, 8'h00); // Latch kept.
		check(nWr[7:0], 8'h04); // No strobe unaddressed.
		giveVerdict();
	end
endmodule
